/* File: rtl/alu_exec_consts.vh */
// Constants for the byte ALU execute stage: opcodes, file addresses,
// register offsets and reset values. Definitions only.
`ifndef ALU_EXEC_CONSTS_VH
`define ALU_EXEC_CONSTS_VH

// Opcode patterns, matched against the instruction's upper bits.
`define OP_ADD_ACC_TO_FILE    6'h07
`define OP_AND_ACC_WITH_FILE  6'h05
`define OP_AND_ACC_WITH_LIT   4'he
`define OP_ABSOLUTE_JUMP      3'h5
`define OP_TRISTATE_LOAD      9'h000

// Instruction fields.
`define DEST_BIT              5
`define FILE_MSB              4

// File addresses with side effects.
`define FILE_TIMER_ZERO       5'h01
`define FILE_PC_LOW           5'h02
`define FILE_IO_PORT_B        5'h06
`define TRISTATE_LOAD_PORT_B_SEL       3'h6

// Program counter.
`define PC_WIDTH              10
`define PC_FORCED_BIT         8

// Register offsets (byte addresses).
`define REG_CTRL              8'h00
`define REG_ACC               8'h04
`define REG_FLAGS             8'h08
`define REG_PORT              8'h0c

// Field positions.
`define CTRL_PRESCALER_TIMER  0
`define CTRL_PC_PAGE          1
`define FLAG_CARRY            0
`define FLAG_DIGIT_CARRY      1
`define FLAG_ZERO             2

// Reset values.
`define CTRL_RESET            8'h00
`define ACC_RESET             8'h00
`define DIR_RESET             8'hff
`define PORT_LATCH_RESET      8'h00

`endif

/* File: rtl/sync_two_flop.v */
// Two-flop synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/1ps
module sync_two_flop #(
   parameter WIDTH = 8
) (
   input  wire             clk,       // Core clock.
   input  wire             rst_n,     // Asynchronous reset, active low.
   input  wire [WIDTH-1:0] async_in,  // Levels from pins.
   output reg  [WIDTH-1:0] sync_out   // Levels in the clock domain.
);
   reg [WIDTH-1:0] meta;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta     <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule // sync_two_flop

/* File: rtl/byte_alu_instruction_execute.v */
// Execute stage for add/AND accumulator instructions plus shared side
// effects: program counter loads, port pin reads, direction latch loads
// and timer prescaler clear, with a classic Wishbone register slave.
// Assumes the fetch stage presents instr with the file operand read
// from file_rdata in the same cycle, and that the register file takes
// file_we/file_waddr/file_wdata one cycle later.
`timescale 1ns/1ps
`include "alu_exec_consts.vh"
module byte_alu_instruction_execute (
   input  wire        clk,             // Core clock, 50 MHz.
   input  wire        rst_n,           // Asynchronous reset, active low.
   input  wire        instr_valid,     // Instruction present this cycle.
   input  wire [11:0] instr,           // Instruction word.
   input  wire [7:0]  file_rdata,      // Operand from the file address.
   input  wire [7:0]  port_pin_in,     // Port pin levels, asynchronous.
   output wire [7:0]  port_pin_out,    // Port output latch.
   output wire [7:0]  port_pin_oe,     // Port driver enable, high drives.
   output reg         file_we,         // File register write pulse.
   output reg  [4:0]  file_waddr,      // File register write address.
   output reg  [7:0]  file_wdata,      // File register write data.
   output reg         pc_load,         // Program counter load pulse.
   output reg  [9:0]  pc_value,        // Program counter load value.
   output reg         prescaler_clear, // Prescaler clear pulse.
   input  wire        wb_cyc_i,        // Wishbone cycle.
   input  wire        wb_stb_i,        // Wishbone strobe.
   input  wire        wb_we_i,         // Wishbone write enable.
   input  wire [7:0]  wb_adr_i,        // Wishbone byte address.
   input  wire [3:0]  wb_sel_i,        // Wishbone byte selects.
   input  wire [31:0] wb_dat_i,        // Wishbone write data.
   output reg  [31:0] wb_dat_o,        // Wishbone read data.
   output reg         wb_ack_o         // Wishbone acknowledge.
);
   // One-hot instruction kinds; K_NONE covers every opcode not run here.
   localparam [3:0] K_NONE = 4'b0001;
   localparam [3:0] K_ADD  = 4'b0010;
   localparam [3:0] K_ANDF = 4'b0100;
   localparam [3:0] K_ANDL = 4'b1000;

   reg  [7:0] acc;
   reg  [7:0] ctrl;
   reg        carry;
   reg        digit_carry_flag;
   reg        zero;
   reg  [7:0] dir_latch;
   reg  [7:0] port_latch;
   wire [7:0] pins_sync;

   reg  [3:0] kind;
   reg  [7:0] operand;
   reg  [8:0] sum;
   reg  [4:0] nibble_sum;
   reg  [7:0] result;
   wire       to_file  = instr[`DEST_BIT];
   wire [4:0] faddr    = instr[`FILE_MSB:0];
   wire       is_jump  = instr_valid &&
                         (instr[11:9] == `OP_ABSOLUTE_JUMP);
   wire       is_tristate_load  = instr_valid &&
                         (instr[11:3] == `OP_TRISTATE_LOAD);
   wire       file_wr  = (kind == K_ADD || kind == K_ANDF) && to_file;
   wire       bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // A write lands at the edge where the master sees ack, so the write and
   // its acknowledge can never fall on two different edges.
   wire       bus_wr   = wb_cyc_i && wb_stb_i && wb_ack_o &&
                         wb_we_i && wb_sel_i[0];

   // Pins come from outside the clock domain, so two flops guard them.
   // Operands from the port address therefore lag the pins by two clocks.
   sync_two_flop #(
      .WIDTH (8)
   ) u_pin_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (port_pin_in),
      .sync_out (pins_sync)
   );

   assign port_pin_out = port_latch;
   assign port_pin_oe  = ~dir_latch;

   // Decode the instruction and form the result in one cycle.
   always @* begin
      kind = K_NONE;
      if (instr_valid) begin
         if (instr[11:6] == `OP_ADD_ACC_TO_FILE) begin
            kind = K_ADD;
         end else if (instr[11:6] == `OP_AND_ACC_WITH_FILE) begin
            kind = K_ANDF;
         end else if (instr[11:8] == `OP_AND_ACC_WITH_LIT) begin
            kind = K_ANDL;
         end
      end
      // The literal form reads no file, so its low bits are no address.
      if (kind == K_ANDL) begin
         operand = instr[7:0];
      end else if (faddr == `FILE_IO_PORT_B) begin
         operand = pins_sync;
      end else begin
         operand = file_rdata;
      end
      sum        = {1'b0, acc} + {1'b0, operand};
      nibble_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
      case (kind)
         K_ADD: begin
            result = sum[7:0];
         end
         K_ANDF, K_ANDL: begin
            result = acc & operand;
         end
         default: begin
            result = acc;
         end
      endcase
   end

   // Accumulator, flags and write-back.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc              <= `ACC_RESET;
         carry            <= 1'b0;
         digit_carry_flag <= 1'b0;
         zero             <= 1'b0;
         file_we          <= 1'b0;
         file_waddr       <= 5'h00;
         file_wdata       <= 8'h00;
      end else begin
         file_we    <= file_wr;
         file_waddr <= faddr;
         file_wdata <= result;
         // An instruction beats a bus write to the accumulator.
         if (kind != K_NONE) begin
            zero <= (result == 8'h00);
            if (!file_wr) begin
               acc <= result;
            end
         end else if (bus_wr && wb_adr_i == `REG_ACC) begin
            acc <= wb_dat_i[7:0];
         end
         // The AND forms leave carry and digit carry as they were.
         if (kind == K_ADD) begin
            carry            <= sum[8];
            digit_carry_flag <= nibble_sum[4];
         end
      end
   end

   // Program counter loads and prescaler clear.
   // The page bit comes from the control register; file writes to the low
   // program counter byte always clear the bit below it.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_load         <= 1'b0;
         pc_value        <= 10'h000;
         prescaler_clear <= 1'b0;
      end else begin
         pc_load         <= is_jump ||
                            (file_wr && faddr == `FILE_PC_LOW);
         prescaler_clear <= file_wr && faddr == `FILE_TIMER_ZERO &&
                            ctrl[`CTRL_PRESCALER_TIMER];
         if (is_jump) begin
            pc_value <= {ctrl[`CTRL_PC_PAGE], instr[8:0]};
         end else begin
            pc_value <= {ctrl[`CTRL_PC_PAGE], 1'b0, result};
         end
      end
   end

   // Port latches.
   // The direction latch resets to all ones so every driver starts off.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_latch  <= `DIR_RESET;
         port_latch <= `PORT_LATCH_RESET;
      end else begin
         if (is_tristate_load && instr[2:0] == `TRISTATE_LOAD_PORT_B_SEL) begin
            dir_latch <= acc;
         end
         if (file_wr && faddr == `FILE_IO_PORT_B) begin
            port_latch <= result;
         end
      end
   end

   // Wishbone slave: ack follows a request by one cycle and lasts one;
   // read data is registered at the request and held until the next one.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl     <= `CTRL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_wr && wb_adr_i == `REG_CTRL) begin
            ctrl <= {6'h00, wb_dat_i[1:0]};
         end
         if (bus_req) begin
            if (wb_adr_i == `REG_CTRL) begin
               wb_dat_o <= {24'h000000, ctrl};
            end else if (wb_adr_i == `REG_ACC) begin
               wb_dat_o <= {24'h000000, acc};
            end else if (wb_adr_i == `REG_FLAGS) begin
               wb_dat_o <= {29'h00000000, zero, digit_carry_flag,
                            carry};
            end else if (wb_adr_i == `REG_PORT) begin
               wb_dat_o <= {8'h00, pins_sync, dir_latch, port_latch};
            end else begin
               wb_dat_o <= 32'h0000_0000;
            end
         end
      end
   end
endmodule // byte_alu_instruction_execute

/* File: bench/byte_alu_instruction_execute_properties.sv */
// Checker for the ALU execute stage: decode side effects at its ports.
// Assumes it is bound to the execute stage and sees only its ports.
`timescale 1ns/1ps
module alu_exec_checker (
   input wire        clk,             // Core clock.
   input wire        rst_n,           // Reset, active low.
   input wire        instr_valid,     // Instruction present.
   input wire [11:0] instr,           // Instruction word.
   input wire [7:0]  file_rdata,      // File operand.
   input wire [7:0]  port_pin_oe,     // Driver enables.
   input wire        file_we,         // File write pulse.
   input wire [4:0]  file_waddr,      // File write address.
   input wire [7:0]  file_wdata,      // File write data.
   input wire        pc_load,         // PC load pulse.
   input wire [9:0]  pc_value,        // PC load value.
   input wire        prescaler_clear  // Prescaler clear pulse.
);
   wire file_op = instr_valid && instr[11:8] == 4'h1 && instr[6];
   wire to_file = file_op && instr[5];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_dest_file;
      to_file |=> file_we && file_waddr == $past(instr[4:0]);
   endproperty
   a_dest_file: assert property (p_dest_file)
      else $error("file destination not written");
   property p_dest_acc;
      file_op && !instr[5] |=> !file_we;
   endproperty
   a_dest_acc: assert property (p_dest_acc)
      else $error("file written for accumulator destination");
   property p_pc_clear;
      to_file && instr[4:0] == 5'h02 |=> pc_load && !pc_value[8];
   endproperty
   a_pc_clear: assert property (p_pc_clear)
      else $error("program counter bit not cleared");
   property p_jump;
      instr_valid && instr[11:9] == 3'h5
         |=> pc_load && pc_value[8:0] == $past(instr[8:0]);
   endproperty
   a_jump: assert property (p_jump)
      else $error("jump target wrong");
   property p_presc;
      prescaler_clear |-> $past(to_file && instr[4:0] == 5'h01);
   endproperty
   a_presc: assert property (p_presc)
      else $error("prescaler cleared without timer write");
   property p_and_zero;
      to_file && !instr[7] && instr[4:0] != 5'h06 && file_rdata == 8'h00
         |=> file_wdata == 8'h00;
   endproperty
   a_and_zero: assert property (p_and_zero)
      else $error("AND with zero not zero");
   property p_tristate_load;
      !$stable(port_pin_oe) |-> $past(instr_valid && instr == 12'h006);
   endproperty
   a_tristate_load: assert property (p_tristate_load)
      else $error("driver enables changed without tristate load");
   property p_one_cycle;
      file_op |=> file_we == $past(instr[5]);
   endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("file op result late");
   c_file: cover property (to_file);
   c_tristate_load: cover property (instr_valid && instr == 12'h006);
   c_presc: cover property (prescaler_clear);
endmodule // alu_exec_checker
bind byte_alu_instruction_execute alu_exec_checker u_alu_exec_checker (
   .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
   .file_rdata(file_rdata), .port_pin_oe(port_pin_oe), .file_we(file_we),
   .file_waddr(file_waddr), .file_wdata(file_wdata), .pc_load(pc_load),
   .pc_value(pc_value), .prescaler_clear(prescaler_clear));

/* File: bench/byte_alu_instruction_execute_test.sv */
// Self-checking bench for the ALU execute stage.
// Assumes the design and its checker are compiled before this file.
`timescale 1ns/1ps
module byte_alu_instruction_execute_test;
   reg         clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0;
   reg  [11:0] instr = 12'h000;
   reg  [7:0]  file_rdata = 8'h00, port_pin_in = 8'h00, adr = 8'h00;
   reg         cyc = 1'b0, stb = 1'b0, we = 1'b0;
   reg  [3:0]  sel = 4'h0;
   reg  [31:0] dat = 32'h0, q;
   wire [7:0]  port_pin_out, port_pin_oe, file_wdata;
   wire [4:0]  file_waddr;
   wire [9:0]  pc_value;
   wire [31:0] wb_dat_o;
   wire        file_we, pc_load, prescaler_clear, wb_ack_o;
   integer     n_fail = 0, samples_checked = 0, cycles = 0;
   byte_alu_instruction_execute u_byte_alu_instruction_execute (
      .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
      .file_rdata(file_rdata), .port_pin_in(port_pin_in),
      .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
      .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
      .pc_load(pc_load), .pc_value(pc_value),
      .prescaler_clear(prescaler_clear), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   always #10 clk = ~clk;
   task give_verdict;
      begin
         $display("checked %0d failed %0d", samples_checked, n_fail);
         if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
         end else begin
            $display("*** FAIL ***");
         end
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         n_fail = n_fail + 1;
         $display("[FAIL] %0t timeout", $time);
         give_verdict;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Classic single Wishbone cycle, held until ack is sampled high.
   task wb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         dat <= d;
         sel <= 4'h1;
         @(posedge clk);
         while (wb_ack_o !== 1'b1) @(posedge clk);
         q = wb_dat_o;
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask
   task ex(input [11:0] i, input [7:0] d);
      begin
         @(posedge clk);
         instr_valid <= 1'b1;
         instr <= i;
         file_rdata <= d;
         @(posedge clk);
         instr_valid <= 1'b0;
         #1;
      end
   endtask
   task t_reset_regs;
      begin
         chk(port_pin_oe, 8'h00);
         wb(1'b0, 8'h0c, 32'h0);
         chk(q[15:0], 16'hff00);
         wb(1'b1, 8'h10, 32'hff);
         wb(1'b0, 8'h10, 32'h0);
         chk(q, 32'h0);
      end
   endtask
   task t_add_acc;
      begin
         wb(1'b1, 8'h04, 32'hf8);
         ex(12'h1c3, 8'h08);
         chk(file_we, 1'b0);
         wb(1'b0, 8'h04, 32'h0);
         chk(q[7:0], 8'h00);
         wb(1'b0, 8'h08, 32'h0);
         chk(q[2:0], 3'h7);
      end
   endtask
   task t_and;
      begin
         wb(1'b1, 8'h04, 32'ha3);
         ex(12'he5f, 8'h00);
         wb(1'b0, 8'h04, 32'h0);
         chk(q[7:0], 8'h03);
         wb(1'b0, 8'h08, 32'h0);
         chk(q[2:0], 3'h3);
         ex(12'h164, 8'hfc);
         chk({file_we, file_wdata}, 9'h100);
         ex(12'h164, 8'h81);
         chk({file_we, file_wdata}, 9'h101);
         wb(1'b0, 8'h08, 32'h0);
         chk(q[2:0], 3'h3);
         ex(12'h164, 8'h00);
         chk({file_we, file_wdata}, 9'h100);
         wb(1'b0, 8'h08, 32'h0);
         chk(q[2:0], 3'h7);
      end
   endtask
   task t_pc;
      begin
         wb(1'b1, 8'h00, 32'h2);
         wb(1'b0, 8'h00, 32'h0);
         chk(q[7:0], 8'h02);
         ex(12'h1e2, 8'h05);
         chk({file_waddr, file_wdata}, 13'h0208);
         chk({pc_load, pc_value}, 11'h608);
         ex(12'hbff, 8'h00);
         chk({pc_load, pc_value}, 11'h7ff);
      end
   endtask
   task t_presc;
      begin
         wb(1'b1, 8'h00, 32'h1);
         ex(12'h1e1, 8'h00);
         chk(prescaler_clear, 1'b1);
         ex(12'h1c1, 8'h00);
         chk(prescaler_clear, 1'b0);
         wb(1'b1, 8'h00, 32'h0);
         ex(12'h1e1, 8'h00);
         chk(prescaler_clear, 1'b0);
      end
   endtask
   task t_port;
      begin
         @(posedge clk);
         port_pin_in <= 8'h5a;
         wb(1'b1, 8'h04, 32'h0);
         ex(12'h1e6, 8'hff);
         chk(file_wdata, 8'h5a);
         chk(port_pin_out, 8'h5a);
         wb(1'b0, 8'h0c, 32'h0);
         chk(q[23:0], 24'h5aff5a);
         wb(1'b1, 8'h04, 32'h0f);
         ex(12'h006, 8'h00);
         chk(port_pin_oe, 8'hf0);
         wb(1'b0, 8'h0c, 32'h0);
         chk(q[15:8], 8'h0f);
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_regs;
      t_add_acc;
      t_and;
      t_pc;
      t_presc;
      t_port;
      give_verdict;
   end
endmodule // byte_alu_instruction_execute_test
